/* verilog/gauge_defines.svh */
// Constants for the gauge status-flag and power-mode block
`ifndef GAUGE_DEFINES_SVH
`define GAUGE_DEFINES_SVH

// ******************************
// Register map (byte addresses)
// ******************************
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_TEMP 12'h008
`define ADDR_CURR 12'h00c
`define ADDR_VOLT 12'h010
`define ADDR_CHARGE_OVERTEMP_LIMIT 12'h014
`define ADDR_DISCHARGE_OVERTEMP_LIMIT 12'h018
`define ADDR_INHIBIT 12'h01c
`define ADDR_SUSPEND 12'h020
`define ADDR_TAPER 12'h024
`define ADDR_SLEEP 12'h028
`define ADDR_HIB 12'h02c
`define ADDR_CAP 12'h030
`define ADDR_EVENT 12'h034

// ******************************
// Control register bits
// ******************************
`define CTRL_SLEEP_EN 0
`define CTRL_SLEEP_PLUS 1
`define CTRL_HIB_REQ 2
`define CTRL_FULL_CAP 3
`define CTRL_CHG_OPT 4
`define CTRL_CHARGING 5

// ******************************
// Event register bits (write one to signal)
// ******************************
`define EV_MEAS 0
`define EV_BAT_IN 1
`define EV_BAT_OUT 2
`define EV_OCV_DONE 3
`define EV_OCV_VALID 4
`define EV_CAL_DONE 5
`define EV_WAKE_CMP 6
`define EV_HOST_CMD 7
`define EV_PROF_DONE 8
`define EV_INIT_DONE 9

// ******************************
// Status register bits
// ******************************
`define ST_OTC 0
`define ST_OTD 1
`define ST_INHIBIT 2
`define ST_SUSPEND 3
`define ST_CHG 4
`define ST_BATGOOD 5
`define ST_HFOSC 6
`define ST_MODE_LSB 8

// ******************************
// Misc
// ******************************
`define TAPER_WINDOWS 2'h2
`define RESET_CAP 16'h0000

`endif

/* verilog/gauge_pkg.sv */
// Types shared by the gauge status-flag and power-mode block
package gauge_pkg;
	// One-hot power mode states
	typedef enum logic [8:0]
	{
		ST_INSERT_CHECK = 9'h001,
		ST_HOST_SERVICE = 9'h002,
		ST_INIT_OCV = 9'h004,
		ST_INIT_PROFILE = 9'h008,
		ST_NORMAL = 9'h010,
		ST_CALIBRATE = 9'h020,
		ST_SLEEP = 9'h040,
		ST_SLEEP_PLUS = 9'h080,
		ST_HIBERNATE = 9'h100
	} power_mode_e;
endpackage

/* verilog/gauge_status_flags.sv */
// Status flags and power-mode state machine of the battery gauge
`include "gauge_defines.svh"

// Summary of operation
// - Charge overtemp after time, current above threshold
// - Discharge overtemp after time, current at or below minus threshold
// - Zero qualification time disables overtemp detection
// - Termination over two taper windows clears charging
// - Termination loads remaining with full capacity
// - Outside inhibit window: inhibit set, battery-good low
// - Inside hysteresis window: inhibit clear, battery-good high
// - Option one: suspend flag outside suspend limits
// - Insertion: OCV, battery-good, then profile selection
// - Halted state wakes for host commands, returns
// - Normal mode when no other mode active
// - Sleep when enabled and current low; HF off
// - Offset calibration before entering sleep
// - Leave sleep on current rise or wake
// - Battery removal outside hibernate returns to insert check
// - Sleep-plus when enabled, current low; oscillators on
// - Leave sleep-plus on traffic, current or wake
// - Hibernate needs request, valid OCV, low current/voltage
// - Only addressed traffic or reset leaves hibernate
module gauge_status_flags
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Pins
	input wire logic bus_addressed_i,
	output logic battery_good_output_o,
	output logic hf_osc_en_o,
	output logic measure_req_o
);
	// ******************************
	// Reset synchroniser
	// ******************************
	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_n;

	// Asynchronous assert, synchronous release
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// ******************************
	// Pin input synchroniser
	// ******************************
	logic addr_s1_q;
	logic addr_s2_q;
	logic addr_prev_q;

	// Two stages before any logic looks at the bus-match pin
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr_s1_q <= 1'b0;
			addr_s2_q <= 1'b0;
			addr_prev_q <= 1'b0;
		end
		else
		begin
			addr_s1_q <= bus_addressed_i;
			addr_s2_q <= addr_s1_q;
			addr_prev_q <= addr_s2_q;
		end
	end

	// ******************************
	// Register file
	// ******************************
	logic [5:0] ctrl_q;
	logic signed [15:0] temp_q;
	logic signed [15:0] curr_q;
	logic [15:0] volt_q;
	logic [31:0] charge_overtemp_limit_q;
	logic [31:0] discharge_overtemp_limit_q;
	logic [31:0] inhibit_q;
	logic [31:0] suspend_q;
	logic [31:0] taper_q;
	logic [31:0] sleep_q;
	logic [31:0] hib_q;
	logic [15:0] full_cap_q;
	logic [15:0] remain_cap_q;
	logic [9:0] event_q;
	logic wr_en;
	logic rd_en;
	logic hit;

	// Address decode used by write enable and error flag
	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = (a <= `ADDR_EVENT) && (a[1:0] == 2'h0);
	endfunction

	assign pready_o = 1'b1;
	assign hit = addr_mapped(paddr_i);
	assign wr_en = psel_i && penable_i && pwrite_i && hit;
	assign rd_en = psel_i && penable_i && !pwrite_i;
	assign pslverr_o = psel_i && penable_i && !hit;

	// Software-written configuration and measurement inputs
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q <= 6'h00;
			temp_q <= 16'sh0000;
			curr_q <= 16'sh0000;
			volt_q <= 16'h0000;
			charge_overtemp_limit_q <= 32'h00000000;
			discharge_overtemp_limit_q <= 32'h00000000;
			inhibit_q <= 32'h00000000;
			suspend_q <= 32'h00000000;
			taper_q <= 32'h00000000;
			sleep_q <= 32'h00000000;
			hib_q <= 32'h00000000;
			full_cap_q <= 16'h0000;
		end
		else if (wr_en)
		begin
			unique case (paddr_i)
				`ADDR_CTRL: ctrl_q <= pwdata_i[5:0];
				`ADDR_TEMP: temp_q <= pwdata_i[15:0];
				`ADDR_CURR: curr_q <= pwdata_i[15:0];
				`ADDR_VOLT: volt_q <= pwdata_i[15:0];
				`ADDR_CHARGE_OVERTEMP_LIMIT: charge_overtemp_limit_q <= pwdata_i;
				`ADDR_DISCHARGE_OVERTEMP_LIMIT: discharge_overtemp_limit_q <= pwdata_i;
				`ADDR_INHIBIT: inhibit_q <= pwdata_i;
				`ADDR_SUSPEND: suspend_q <= pwdata_i;
				`ADDR_TAPER: taper_q <= pwdata_i;
				`ADDR_SLEEP: sleep_q <= pwdata_i;
				`ADDR_HIB: hib_q <= pwdata_i;
				`ADDR_CAP: full_cap_q <= pwdata_i[15:0];
				default: ;
			endcase
		end
	end

	// Event strobes: one-cycle pulses from a write of ones
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			event_q <= 10'h000;
		else if (wr_en && paddr_i == `ADDR_EVENT)
			event_q <= pwdata_i[9:0];
		else
			event_q <= 10'h000;
	end

	// Field views (signed temperatures are 8-bit fields)
	logic signed [15:0] charge_overtemp_limit_limit;
	logic signed [15:0] charge_overtemp_limit_recov;
	logic [7:0] charge_overtemp_time;
	logic signed [15:0] discharge_overtemp_limit_limit;
	logic signed [15:0] discharge_overtemp_limit_recov;
	logic [7:0] discharge_overtemp_time;
	logic signed [15:0] inh_lo;
	logic signed [15:0] inh_hi;
	logic signed [15:0] hys;
	logic signed [15:0] sus_lo;
	logic signed [15:0] sus_hi;
	logic signed [15:0] chg_thr;
	logic signed [15:0] dsg_thr;
	assign charge_overtemp_limit_limit = 16'(signed'(charge_overtemp_limit_q[7:0]));
	assign charge_overtemp_limit_recov = 16'(signed'(charge_overtemp_limit_q[15:8]));
	assign charge_overtemp_time = charge_overtemp_limit_q[23:16];
	assign discharge_overtemp_limit_limit = 16'(signed'(discharge_overtemp_limit_q[7:0]));
	assign discharge_overtemp_limit_recov = 16'(signed'(discharge_overtemp_limit_q[15:8]));
	assign discharge_overtemp_time = discharge_overtemp_limit_q[23:16];
	assign inh_lo = 16'(signed'(inhibit_q[7:0]));
	assign inh_hi = 16'(signed'(inhibit_q[15:8]));
	assign hys = 16'(signed'(inhibit_q[23:16]));
	assign sus_lo = 16'(signed'(suspend_q[7:0]));
	assign sus_hi = 16'(signed'(suspend_q[15:8]));
	assign chg_thr = signed'(suspend_q[31:16]);
	assign dsg_thr = signed'(hib_q[31:16]);

	// ******************************
	// Over-temperature flags
	// ******************************
	logic otc_q;
	logic otd_q;
	logic [7:0] otc_cnt_q;
	logic [7:0] otd_cnt_q;
	logic charging;
	logic meas;
	assign charging = ctrl_q[`CTRL_CHARGING];
	assign meas = event_q[`EV_MEAS];

	// Qualification time counted in measurement periods
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			otc_q <= 1'b0;
			otc_cnt_q <= 8'h00;
		end
		else if (charge_overtemp_time == 8'h00)
		begin
			otc_q <= 1'b0;
			otc_cnt_q <= 8'h00;
		end
		else if (meas)
		begin
			if (otc_q && temp_q <= charge_overtemp_limit_recov)
				otc_q <= 1'b0;
			else if (charging && temp_q >= charge_overtemp_limit_limit && curr_q > chg_thr)
			begin
				if (otc_cnt_q + 8'h01 >= charge_overtemp_time)
					otc_q <= 1'b1;
				else
					otc_cnt_q <= otc_cnt_q + 8'h01;
			end
			else
				otc_cnt_q <= 8'h00;
		end
	end

	// Discharge side mirrors the charge side
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			otd_q <= 1'b0;
			otd_cnt_q <= 8'h00;
		end
		else if (discharge_overtemp_time == 8'h00)
		begin
			otd_q <= 1'b0;
			otd_cnt_q <= 8'h00;
		end
		else if (meas)
		begin
			if (otd_q && temp_q <= discharge_overtemp_limit_recov)
				otd_q <= 1'b0;
			else if (!charging && temp_q >= discharge_overtemp_limit_limit && curr_q <= -dsg_thr)
			begin
				if (otd_cnt_q + 8'h01 >= discharge_overtemp_time)
					otd_q <= 1'b1;
				else
					otd_cnt_q <= otd_cnt_q + 8'h01;
			end
			else
				otd_cnt_q <= 8'h00;
		end
	end

	// ******************************
	// Charge termination
	// ******************************
	logic chg_q;
	logic [1:0] taper_ok_q;
	logic [15:0] win_cnt_q;
	logic [15:0] accum_q;
	logic window_good;
	logic taper_v;
	// Taper field layout: [7:0] window, [15:8] min charge, [23:16] current, [31:24] voltage
	assign taper_v = volt_q > (16'(sleep_q[31:16]) - 16'(taper_q[31:24]));
	assign window_good = (curr_q < 16'(signed'({1'b0, taper_q[23:16]})))
		&& (accum_q > 16'(taper_q[15:8])) && taper_v;

	// Window count and capacity accumulation per measurement
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			win_cnt_q <= 16'h0000;
			accum_q <= 16'h0000;
			taper_ok_q <= 2'h0;
			chg_q <= 1'b0;
			remain_cap_q <= `RESET_CAP;
		end
		else
		begin
			// Windows restart whenever charging stops, so a new charge sets the flag again
			if (!charging)
			begin
				chg_q <= 1'b0;
				taper_ok_q <= 2'h0;
				win_cnt_q <= 16'h0000;
				accum_q <= 16'h0000;
			end
			else if (taper_ok_q == 2'h0 && !chg_q && win_cnt_q == 16'h0000)
				chg_q <= 1'b1;
			if (meas && charging)
			begin
				accum_q <= accum_q + (curr_q > 0 ? curr_q : 16'h0000);
				if (win_cnt_q + 16'h0001 >= 16'(taper_q[7:0]))
				begin
					win_cnt_q <= 16'h0000;
					accum_q <= 16'h0000;
					if (window_good)
					begin
						if (taper_ok_q + 2'h1 >= `TAPER_WINDOWS && chg_q)
						begin
							chg_q <= 1'b0;
							if (ctrl_q[`CTRL_FULL_CAP])
								remain_cap_q <= full_cap_q;
						end
						taper_ok_q <= (taper_ok_q == `TAPER_WINDOWS) ? taper_ok_q
							: taper_ok_q + 2'h1;
					end
					else
						taper_ok_q <= 2'h0;
				end
				else
					win_cnt_q <= win_cnt_q + 16'h0001;
			end
		end
	end

	// ******************************
	// Charge inhibit and suspend
	// ******************************
	logic inhibit_q_f;
	logic suspend_q_f;
	logic in_hys_window;
	assign in_hys_window = (temp_q >= inh_lo + hys) && (temp_q <= inh_hi - hys);

	// Temperature window flags, evaluated each measurement
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			inhibit_q_f <= 1'b0;
			suspend_q_f <= 1'b0;
		end
		else if (meas)
		begin
			if (temp_q < inh_lo || temp_q > inh_hi)
				inhibit_q_f <= 1'b1;
			else if (in_hys_window)
				inhibit_q_f <= 1'b0;
			if (!ctrl_q[`CTRL_CHG_OPT])
				suspend_q_f <= 1'b0;
			else if (temp_q < sus_lo || temp_q > sus_hi)
				suspend_q_f <= 1'b1;
			else if (in_hys_window)
				suspend_q_f <= 1'b0;
		end
	end

	// ******************************
	// Power mode state machine
	// ******************************
	gauge_pkg::power_mode_e mode_q;
	logic bat_good_q;
	logic ocv_valid_q;
	logic cur_low;
	logic cur_high;
	logic hib_cond;
	logic addressed;
	assign cur_low = curr_q < signed'(sleep_q[15:0]);
	assign cur_high = curr_q > signed'(sleep_q[15:0]);
	assign hib_cond = ((curr_q < 0 ? -curr_q : curr_q) < signed'(hib_q[7:0] & 16'h00ff))
		|| (volt_q < 16'(hib_q[15:8]) << 4);
	assign addressed = addr_s2_q && !addr_prev_q;

	// Mode sequencing; normal is the fallback for calibrate, sleep and sleep-plus
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= gauge_pkg::ST_INSERT_CHECK;
			bat_good_q <= 1'b0;
			ocv_valid_q <= 1'b0;
		end
		else
		begin
			if (event_q[`EV_OCV_DONE])
				ocv_valid_q <= event_q[`EV_OCV_VALID];
			if (event_q[`EV_BAT_OUT] && mode_q != gauge_pkg::ST_HIBERNATE)
			begin
				mode_q <= gauge_pkg::ST_INSERT_CHECK;
				bat_good_q <= 1'b0;
			end
			else
			begin
				unique case (mode_q)
					gauge_pkg::ST_INSERT_CHECK:
						if (event_q[`EV_BAT_IN])
							mode_q <= gauge_pkg::ST_INIT_OCV;
						else if (event_q[`EV_HOST_CMD])
							mode_q <= gauge_pkg::ST_HOST_SERVICE;
					gauge_pkg::ST_HOST_SERVICE:
						if (event_q[`EV_INIT_DONE])
							mode_q <= gauge_pkg::ST_INSERT_CHECK;
					gauge_pkg::ST_INIT_OCV:
						if (event_q[`EV_OCV_DONE])
						begin
							bat_good_q <= 1'b1;
							mode_q <= gauge_pkg::ST_INIT_PROFILE;
						end
					gauge_pkg::ST_INIT_PROFILE:
						if (event_q[`EV_PROF_DONE])
							mode_q <= gauge_pkg::ST_NORMAL;
					gauge_pkg::ST_NORMAL:
						if (ctrl_q[`CTRL_HIB_REQ] && ocv_valid_q && hib_cond)
						begin
							mode_q <= gauge_pkg::ST_HIBERNATE;
							bat_good_q <= 1'b0;
						end
						else if (ctrl_q[`CTRL_SLEEP_EN] && cur_low)
							mode_q <= gauge_pkg::ST_CALIBRATE;
						else if (ctrl_q[`CTRL_SLEEP_PLUS] && cur_low)
							mode_q <= gauge_pkg::ST_SLEEP_PLUS;
					gauge_pkg::ST_CALIBRATE:
						if (!cur_low)
							mode_q <= gauge_pkg::ST_NORMAL;
						else if (event_q[`EV_CAL_DONE])
							mode_q <= gauge_pkg::ST_SLEEP;
					gauge_pkg::ST_SLEEP:
						if (cur_high || event_q[`EV_WAKE_CMP] || !ctrl_q[`CTRL_SLEEP_EN])
							mode_q <= gauge_pkg::ST_NORMAL;
					gauge_pkg::ST_SLEEP_PLUS:
						if (cur_high || event_q[`EV_WAKE_CMP] || addressed
							|| !ctrl_q[`CTRL_SLEEP_PLUS])
							mode_q <= gauge_pkg::ST_NORMAL;
					gauge_pkg::ST_HIBERNATE:
						if (addressed)
							mode_q <= gauge_pkg::ST_INIT_OCV;
					default:
						mode_q <= gauge_pkg::ST_INSERT_CHECK;
				endcase
			end
		end
	end

	// Battery-good follows init and the inhibit window; gating keeps it recoverable
	logic bat_good_out;
	assign bat_good_out = bat_good_q && !inhibit_q_f;

	// Measuring requested in normal, calibrate, sleep and sleep-plus; off otherwise
	logic measuring;
	assign measuring = (mode_q == gauge_pkg::ST_NORMAL) || (mode_q == gauge_pkg::ST_SLEEP)
		|| (mode_q == gauge_pkg::ST_SLEEP_PLUS) || (mode_q == gauge_pkg::ST_CALIBRATE);

	// Registered pin outputs
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			battery_good_output_o <= 1'b0;
			hf_osc_en_o <= 1'b1;
			measure_req_o <= 1'b0;
		end
		else
		begin
			battery_good_output_o <= bat_good_out;
			hf_osc_en_o <= (mode_q != gauge_pkg::ST_SLEEP)
				&& (mode_q != gauge_pkg::ST_HIBERNATE);
			measure_req_o <= measuring;
		end
	end

	// ******************************
	// Read mux
	// ******************************
	logic [31:0] status_w;
	assign status_w = {6'h00, remain_cap_q[0], 8'h00, mode_q[8:0], 1'b0,
		hf_osc_en_o, bat_good_out, chg_q, suspend_q_f, inhibit_q_f, otd_q, otc_q};

	// Registered read data, zero for unmapped addresses
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			prdata_o <= 32'h00000000;
		else if (psel_i && !penable_i && !pwrite_i)
		begin
			unique case (paddr_i)
				`ADDR_CTRL: prdata_o <= {26'h0000000, ctrl_q};
				`ADDR_STATUS: prdata_o <= status_w;
				`ADDR_TEMP: prdata_o <= {16'h0000, temp_q};
				`ADDR_CURR: prdata_o <= {16'h0000, curr_q};
				`ADDR_VOLT: prdata_o <= {16'h0000, volt_q};
				`ADDR_CHARGE_OVERTEMP_LIMIT: prdata_o <= charge_overtemp_limit_q;
				`ADDR_DISCHARGE_OVERTEMP_LIMIT: prdata_o <= discharge_overtemp_limit_q;
				`ADDR_INHIBIT: prdata_o <= inhibit_q;
				`ADDR_SUSPEND: prdata_o <= suspend_q;
				`ADDR_TAPER: prdata_o <= taper_q;
				`ADDR_SLEEP: prdata_o <= sleep_q;
				`ADDR_HIB: prdata_o <= hib_q;
				`ADDR_CAP: prdata_o <= {remain_cap_q, full_cap_q};
				default: prdata_o <= 32'h00000000;
			endcase
		end
	end
endmodule

/* test/gauge_status_flags_sva.sv */
// Port-level assertions for the gauge status-flag block
`include "gauge_defines.svh"

module gauge_status_flags_sva
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Pins
	input wire logic bus_addressed_i,
	input wire logic battery_good_output_o,
	input wire logic hf_osc_en_o,
	input wire logic measure_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] ctrl_q;
	logic [2:0] quiet_q;
	logic wr_acc;
	logic hib;
	logic slp;
	logic unmapped;
	// Mode views; only hibernate has both outputs low
	assign hib = !hf_osc_en_o && !measure_req_o;
	assign slp = !hf_osc_en_o && measure_req_o;
	assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;
	assign unmapped = paddr_i[1:0] != 2'h0 || paddr_i > `ADDR_EVENT;
	// Shadow of the control word as the host wrote it
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_q <= 6'h00;
		else if (wr_acc && paddr_i == `ADDR_CTRL)
			ctrl_q <= pwdata_i[5:0];
	end
	// Quiet cycles on the bus line; saturates so it never wraps
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			quiet_q <= 3'h0;
		else if (bus_addressed_i)
			quiet_q <= 3'h0;
		else if (quiet_q != 3'h7)
			quiet_q <= quiet_q + 3'h1;
	end
	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_bat_out;
		wr_acc && paddr_i == `ADDR_EVENT && pwdata_i[`EV_BAT_OUT] && hf_osc_en_o && measure_req_o;
	endsequence
	sequence s_wake_edge;
		hib && !bus_addressed_i ##1 hib && bus_addressed_i;
	endsequence
	AST_READY: assert property (pready_o)
		else $error("ready low");
	AST_SLVERR: assert property (psel_i && penable_i |-> pslverr_o == unmapped)
		else $error("slave error wrong");
	AST_RD_ZERO: assert property (psel_i && penable_i && !pwrite_i && unmapped |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	AST_SLEEP_ENTRY: assert property ($rose(slp) |-> ctrl_q[`CTRL_SLEEP_EN])
		else $error("sleep without enable");
	AST_HIB_ENTRY: assert property ($rose(hib) |-> ctrl_q[`CTRL_HIB_REQ])
		else $error("hibernate without request");
	AST_HIB_HOLD: assert property (hib && quiet_q == 3'h7 && !psel_i |=> hib)
		else $error("hibernate left without traffic");
	AST_HIB_WAKE: assert property (s_wake_edge |-> ##[1:8] !hib)
		else $error("addressed traffic did not wake");
	AST_BAT_OUT: assert property (s_bat_out |-> ##[1:6] !measure_req_o && !battery_good_output_o)
		else $error("removal did not halt");
endmodule

bind gauge_status_flags gauge_status_flags_sva u_sva
(
	.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i),
	.psel_i(psel_i),
	.penable_i(penable_i),
	.pwrite_i(pwrite_i),
	.paddr_i(paddr_i),
	.pwdata_i(pwdata_i),
	.prdata_o(prdata_o),
	.pready_o(pready_o),
	.pslverr_o(pslverr_o),
	.bus_addressed_i(bus_addressed_i),
	.battery_good_output_o(battery_good_output_o),
	.hf_osc_en_o(hf_osc_en_o),
	.measure_req_o(measure_req_o)
);

/* test/host_bus_model.sv */
// Host side of the serial bus: frames addressed to the gauge
module host_bus_model
(
	// Clock
	input wire logic clk_i,
	// Control from the bench
	input wire logic frame_req_i,
	// Line seen by the gauge
	output logic bus_addressed_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left_q = 4'h0;
	// Frame length counter; line idles low between frames
	always_ff @(posedge clk_i)
	begin
		if (frame_req_i && left_q == 4'h0)
			left_q <= 4'h8;
		else if (left_q != 4'h0)
			left_q <= left_q - 4'h1;
	end
	assign bus_addressed_o = left_q != 4'h0;
endmodule

/* test/tb_gauge_status_flags.sv */
// Self-checking testbench for the gauge status-flag block
`include "gauge_defines.svh"

module tb_gauge_status_flags;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic frame_req = 1'b0;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic pready;
	logic pslverr;
	logic rerr;
	logic bus_addr;
	logic bg;
	logic hf;
	logic meas;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;

	gauge_status_flags u_gauge_status_flags
	(
		.ref_clk_i(ref_clk),
		.rst_n_i(rst_n),
		.psel_i(psel),
		.penable_i(penable),
		.pwrite_i(pwrite),
		.paddr_i(paddr),
		.pwdata_i(pwdata),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.bus_addressed_i(bus_addr),
		.battery_good_output_o(bg),
		.hf_osc_en_o(hf),
		.measure_req_o(meas)
	);

	host_bus_model u_host_bus_model
	(
		.clk_i(ref_clk),
		.frame_req_i(frame_req),
		.bus_addressed_o(bus_addr)
	);

	// 250 MHz clock
	initial
		forever #2 ref_clk = ~ref_clk;

	// Hang guard; a full run needs a few hundred cycles
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end

	// ****************
	// Helpers
	// ****************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 16)
		begin
			n++;
			@(posedge ref_clk);
		end
		if (n == 16)
			bad_count++;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic ev(input logic [31:0] bits);
		apb(1'b1, `ADDR_EVENT, bits);
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic status(input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		check_val(rdata & m, e);
	endtask

	// Pins read mid-cycle, well clear of the launching edge
	task automatic pins(input logic [2:0] m, input logic [2:0] e);
		@(negedge ref_clk);
		check_val({29'h0, {bg, hf, meas} & m}, {29'h0, e});
	endtask

	task automatic frame();
		@(posedge ref_clk);
		frame_req <= 1'b1;
		@(posedge ref_clk);
		frame_req <= 1'b0;
		repeat (14) @(posedge ref_clk);
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		pins(3'b111, 3'b010);
		status(32'h1ff00, 32'h100);
		apb(1'b0, 12'h040, 32'h0);
		check_val(rdata, 32'h0);
		check_val({31'h0, rerr}, 32'h1);
	endtask

	task automatic t_insert();
		// Inhibit window nested inside the suspend window
		apb(1'b1, `ADDR_INHIBIT, 32'h00023205);
		apb(1'b1, `ADDR_SUSPEND, 32'h00103c02);
		apb(1'b1, `ADDR_TEMP, 32'h14);
		ev(32'h80);
		status(32'h1ff00, 32'h200);
		ev(32'h200);
		status(32'h1ff00, 32'h100);
		ev(32'h2);
		status(32'h1ff00, 32'h400);
		pins(3'b111, 3'b010);
		ev(32'h18);
		status(32'h1ff00, 32'h800);
		pins(3'b100, 3'b100);
		ev(32'h100);
		status(32'h1ff00, 32'h1000);
		pins(3'b111, 3'b111);
	endtask

	task automatic t_inhibit();
		logic [7:0] t [4] = '{8'h33, 8'h3d, 8'h31, 8'h14};
		logic [3:0] f [4] = '{4'h4, 4'hc, 4'hc, 4'h0};
		apb(1'b1, `ADDR_CTRL, 32'h10);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, `ADDR_TEMP, {24'h0, t[i]});
			ev(32'h1);
			status(32'hc, {28'h0, f[i]});
			pins(3'b100, {f[i] == 4'h0, 2'b00});
		end
	endtask

	// Discharge first: the charging control bit stays clear until this task sets it
	task automatic t_overtemp();
		apb(1'b1, `ADDR_CURR, 32'hffe0);
		apb(1'b1, `ADDR_HIB, 32'h00100000);
		apb(1'b1, `ADDR_DISCHARGE_OVERTEMP_LIMIT, 32'h00022c30);
		apb(1'b1, `ADDR_TEMP, 32'h30);
		repeat (3) ev(32'h1);
		status(32'h2, 32'h2);
		apb(1'b1, `ADDR_TEMP, 32'h2c);
		ev(32'h1);
		status(32'h2, 32'h0);
		apb(1'b1, `ADDR_CTRL, 32'h30);
		apb(1'b1, `ADDR_CURR, 32'h20);
		apb(1'b1, `ADDR_CHARGE_OVERTEMP_LIMIT, 32'h0000282d);
		apb(1'b1, `ADDR_TEMP, 32'h2d);
		repeat (3) ev(32'h1);
		status(32'h1, 32'h0);
		apb(1'b1, `ADDR_CHARGE_OVERTEMP_LIMIT, 32'h0002282d);
		ev(32'h1);
		status(32'h1, 32'h0);
		repeat (2) ev(32'h1);
		status(32'h1, 32'h1);
		apb(1'b1, `ADDR_TEMP, 32'h28);
		ev(32'h1);
		status(32'h1, 32'h0);
	endtask

	// Two windows of two measurements each, still charging, then termination
	task automatic t_taper();
		apb(1'b1, `ADDR_CAP, 32'h1234);
		apb(1'b1, `ADDR_TAPER, 32'h10300802);
		apb(1'b1, `ADDR_SLEEP, 32'h01000000);
		apb(1'b1, `ADDR_VOLT, 32'hf8);
		apb(1'b1, `ADDR_CTRL, 32'h38);
		repeat (3) ev(32'h1);
		status(32'h10, 32'h10);
		ev(32'h1);
		status(32'h10, 32'h0);
		apb(1'b0, `ADDR_CAP, 32'h0);
		check_val(rdata, 32'h12341234);
	endtask

	// Current equal to the sleep level neither enters nor leaves, isolating wakes
	task automatic t_sleep();
		apb(1'b1, `ADDR_CURR, 32'h10);
		apb(1'b1, `ADDR_SLEEP, 32'h40);
		apb(1'b1, `ADDR_CTRL, 32'h11);
		ev(32'h1);
		status(32'h1ff00, 32'h2000);
		ev(32'h20);
		pins(3'b011, 3'b001);
		apb(1'b1, `ADDR_CURR, 32'h40);
		ev(32'h40);
		status(32'h1ff00, 32'h1000);
		pins(3'b011, 3'b011);
		apb(1'b1, `ADDR_CTRL, 32'h12);
		apb(1'b1, `ADDR_CURR, 32'h10);
		ev(32'h1);
		status(32'h1ff00, 32'h8000);
		pins(3'b011, 3'b011);
		apb(1'b1, `ADDR_CURR, 32'h40);
		frame();
		status(32'h1ff00, 32'h1000);
	endtask

	task automatic t_hib();
		apb(1'b1, `ADDR_CTRL, 32'h14);
		apb(1'b1, `ADDR_HIB, 32'h00100020);
		apb(1'b1, `ADDR_CURR, 32'h10);
		ev(32'h19);
		pins(3'b011, 3'b000);
		repeat (20) @(posedge ref_clk);
		pins(3'b011, 3'b000);
		frame();
		pins(3'b010, 3'b010);
		status(32'h1ff00, 32'h400);
		apb(1'b1, `ADDR_CTRL, 32'h10);
		ev(32'h18);
		ev(32'h100);
		status(32'h1ff00, 32'h1000);
		ev(32'h4);
		status(32'h1ff00, 32'h100);
		pins(3'b111, 3'b010);
	endtask

	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_insert();
		t_inhibit();
		t_overtemp();
		t_taper();
		t_sleep();
		t_hib();
		complete_run();
	end
endmodule
